// >>> verilog/tcs_timer.sv
// Purpose: clock select and 16-bit counter core of a general-purpose timer
// Assumes: host bus request taken on every rising clk edge
// Notes: read data appears the cycle after the read strobe
`timescale 1ns/100ps
module tcs_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host bus
    input wire tcs_pkg::tcs_bus_req_type bus_req,
    output logic [7:0] rd_data,
    // pins and loose controls
    input wire logic external_count_pin,
    input wire logic presc_clear,
    input wire logic count_clear,
    // status
    output logic [15:0] timer_count,
    output logic count_floor,
    output logic count_ceiling,
    output logic overflow_flag,
    output logic timer_tick,
    output logic [tcs_pkg::TCS_PRESC_W-1:0] prescaler_count
);
    import tcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [3:0] tcs_mode(input logic [7:0] ca, input logic [7:0] cb);
        // mode field split over two control registers
        tcs_mode = {cb[TCS_WGMH_MSB:TCS_WGMH_LSB], ca[TCS_WGML_MSB:TCS_WGML_LSB]};
    endfunction : tcs_mode

    function automatic logic [15:0] tcs_top(input logic [3:0] md, input logic [15:0] ca);
        tcs_top = (md == TCS_WGM_CTC_A || md == TCS_WGM_UPDN_A) ? ca : TCS_MAX;
    endfunction : tcs_top

    ////////////////////////////////////////////////////////////////////////
    // sub-blocks
    logic [3:0] taps;
    logic rise;
    logic fall;

    tcs_prescaler u_presc (
        .clk(clk),
        .rst(rst),
        .presc_clear(presc_clear),
        .taps(taps),
        .presc_count(prescaler_count)
    );

    tcs_pin_edge u_pin (
        .clk(clk),
        .rst(rst),
        .external_count_pin(external_count_pin),
        .rise(rise),
        .fall(fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    tcs_state_type st_q;
    tcs_state_type st_d;
    logic [2:0] cs;
    logic [3:0] mode;
    logic [15:0] top;
    logic tick;
    logic wr_cnt;
    logic rd_cnt;

    assign cs = st_q.ctrl_b[TCS_CS_MSB:TCS_CS_LSB];
    assign mode = tcs_mode(st_q.ctrl_a, st_q.ctrl_b);
    assign top = tcs_top(mode, st_q.cmp_a);
    assign wr_cnt = bus_req.wr && bus_req.addr == TCS_ADDR_CNT_LO;
    assign rd_cnt = bus_req.rd && bus_req.addr == TCS_ADDR_CNT_LO;

    ////////////////////////////////////////////////////////////////////////
    // clock select
    always_comb begin
        unique case (cs)
            TCS_CS_STOP: tick = 1'b0;
            TCS_CS_SYS: tick = 1'b1;
            // taps fire on prescaler phase, hence 1 to N cycles to first count
            TCS_CS_DIV8: tick = taps[0];
            TCS_CS_DIV64: tick = taps[1];
            TCS_CS_DIV256: tick = taps[2];
            TCS_CS_DIV1024: tick = taps[3];
            // pin edges go straight to the counter, never through the divider
            TCS_CS_EXT_FALL: tick = fall;
            TCS_CS_EXT_RISE: tick = rise;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus, counter and flags
    always_comb begin
        st_d = st_q;
        st_d.tick = tick;
        // count, clear or write, in rising priority
        if (tick) begin
            unique case (mode)
                TCS_WGM_CTC_A: begin
                    st_d.count = (st_q.count == top) ? TCS_FLOOR : st_q.count + TCS_STEP;
                    st_d.down = 1'b0;
                end
                TCS_WGM_UPDN_A: begin
                    if (!st_q.down && st_q.count >= top) begin
                        st_d.down = 1'b1;
                        st_d.count = st_q.count - TCS_STEP;
                    end else if (st_q.down && st_q.count == TCS_FLOOR) begin
                        st_d.down = 1'b0;
                        st_d.count = st_q.count + TCS_STEP;
                    end else begin
                        st_d.count = st_q.down ? st_q.count - TCS_STEP : st_q.count + TCS_STEP;
                    end
                end
                default: begin
                    st_d.count = st_q.count + TCS_STEP;
                    st_d.down = 1'b0;
                end
            endcase
        end
        if (count_clear) begin
            st_d.count = TCS_FLOOR;
        end
        // host writes
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                TCS_ADDR_CTRL_A: st_d.ctrl_a = bus_req.wdata;
                TCS_ADDR_CTRL_B: st_d.ctrl_b = bus_req.wdata;
                // all high bytes land in the single shared holding byte
                TCS_ADDR_CNT_HI, TCS_ADDR_CMPA_HI, TCS_ADDR_CMPB_HI: st_d.hold = bus_req.wdata;
                // writing low takes the held high byte in the same cycle and wins
                TCS_ADDR_CNT_LO: st_d.count = {st_q.hold, bus_req.wdata};
                TCS_ADDR_CMPA_LO: st_d.cmp_a = {st_q.hold, bus_req.wdata};
                TCS_ADDR_CMPB_LO: st_d.cmp_b = {st_q.hold, bus_req.wdata};
                default: begin
                end
            endcase
        end
        // host reads; unmapped locations return zero
        st_d.rdata = TCS_BYTE_RST;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                TCS_ADDR_CTRL_A: st_d.rdata = st_q.ctrl_a;
                TCS_ADDR_CTRL_B: st_d.rdata = st_q.ctrl_b;
                TCS_ADDR_CNT_LO: begin
                    st_d.rdata = st_q.count[7:0];
                    st_d.hold = st_q.count[15:8];
                end
                TCS_ADDR_CNT_HI: st_d.rdata = st_q.hold;
                // compare bytes read directly, holding byte untouched
                TCS_ADDR_CMPA_LO: st_d.rdata = st_q.cmp_a[7:0];
                TCS_ADDR_CMPA_HI: st_d.rdata = st_q.cmp_a[15:8];
                TCS_ADDR_CMPB_LO: st_d.rdata = st_q.cmp_b[7:0];
                TCS_ADDR_CMPB_HI: st_d.rdata = st_q.cmp_b[15:8];
                TCS_ADDR_FLAGS: st_d.rdata = {7'h00, st_q.ovf};
                default: st_d.rdata = TCS_BYTE_RST;
            endcase
        end
        // overflow: write one clears, a same-cycle set still wins
        if (bus_req.wr && bus_req.addr == TCS_ADDR_FLAGS && bus_req.wdata[TCS_OVF_BIT]) begin
            st_d.ovf = 1'b0;
        end
        if (tick && !wr_cnt && !count_clear) begin
            if (mode == TCS_WGM_UPDN_A) begin
                st_d.ovf = st_d.ovf | (st_q.down && st_q.count == TCS_FLOOR);
            end else begin
                st_d.ovf = st_d.ovf | (st_q.count == TCS_MAX);
            end
        end
        // registered from the next value so they track the count exactly
        st_d.floor = st_d.count == TCS_FLOOR;
        st_d.ceil = st_d.count == tcs_top(tcs_mode(st_d.ctrl_a, st_d.ctrl_b), st_d.cmp_a);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.floor <= 1'b1;
            st_q.ceil <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rdata;
    assign timer_count = st_q.count;
    assign count_floor = st_q.floor;
    assign count_ceiling = st_q.ceil;
    assign overflow_flag = st_q.ovf;
    assign timer_tick = st_q.tick;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb_clk @(posedge clk);
    endclocking
    default disable iff (rst);

    logic quiet;
    assign quiet = !wr_cnt && !count_clear;

    property p_sys_rate;
        cs == TCS_CS_SYS && mode == TCS_WGM_NORMAL && quiet |=> st_q.count == $past(st_q.count) + TCS_STEP;
    endproperty
    a_sys_rate: assert property (p_sys_rate) else $error("system clock select did not count");

    property p_stopped;
        cs == TCS_CS_STOP && quiet |=> $stable(st_q.count);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped counter moved");

    property p_div8_phase;
        cs == TCS_CS_DIV8 && quiet && mode == TCS_WGM_NORMAL && prescaler_count[2:0] == 3'h7 |=>
            timer_count == $past(timer_count) + TCS_STEP;
    endproperty
    a_div8_phase: assert property (p_div8_phase) else $error("divide by 8 tick off phase");

    property p_presc_free;
        // the release edge itself still holds the prescaler in reset
        !rst && !presc_clear |=> prescaler_count == $past(prescaler_count) + TCS_PRESC_STEP;
    endproperty
    a_presc_free: assert property (p_presc_free) else $error("prescaler did not run");

    property p_presc_clear;
        // a clear may be held for several cycles; the period restarts when it drops
        presc_clear ##1 !presc_clear |-> prescaler_count == TCS_PRESC_RST ##7 taps[0];
    endproperty
    a_presc_clear: assert property (p_presc_clear) else $error("prescaler restart wrong");

    property p_ext_rise;
        cs == TCS_CS_EXT_RISE && quiet && mode == TCS_WGM_NORMAL && rise |=> st_q.count != $past(st_q.count);
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge not counted");

    property p_ext_direct;
        cs == TCS_CS_EXT_FALL && quiet && mode == TCS_WGM_NORMAL |=>
            timer_count == $past(timer_count) + {15'h0000, $past(fall)};
    endproperty
    a_ext_direct: assert property (p_ext_direct) else $error("falling tick not from pin");

    property p_write_wins;
        wr_cnt |=> st_q.count == {$past(st_q.hold), $past(bus_req.wdata)};
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost");

    property p_clear;
        count_clear && !wr_cnt |=> st_q.count == TCS_FLOOR;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left bits set");

    property p_read_copy;
        rd_cnt |=> st_q.hold == $past(st_q.count[15:8]) && rd_data == $past(st_q.count[7:0]);
    endproperty
    a_read_copy: assert property (p_read_copy) else $error("low read did not copy high byte");

    property p_high_hold;
        bus_req.wr && bus_req.addr == TCS_ADDR_CMPB_HI |=> st_q.hold == $past(bus_req.wdata);
    endproperty
    a_high_hold: assert property (p_high_hold) else $error("shared holding byte not loaded");

    property p_cmp_direct;
        bus_req.rd && bus_req.addr == TCS_ADDR_CMPA_HI |=> rd_data == $past(st_q.cmp_a[15:8]) && $stable(st_q.hold);
    endproperty
    a_cmp_direct: assert property (p_cmp_direct) else $error("compare read used holding byte");

    property p_floor;
        count_floor == (timer_count == TCS_FLOOR);
    endproperty
    a_floor: assert property (p_floor) else $error("floor flag disagrees with count");

    property p_ovf;
        tick && quiet && mode == TCS_WGM_NORMAL && st_q.count == TCS_MAX |=> overflow_flag && count_floor;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged at wrap");

    property p_ctc_wrap;
        tick && quiet && mode == TCS_WGM_CTC_A && st_q.count == top |=> timer_count == TCS_FLOOR;
    endproperty
    a_ctc_wrap: assert property (p_ctc_wrap) else $error("compare clear mode did not restart");

    property p_updn_turn;
        tick && quiet && mode == TCS_WGM_UPDN_A && !st_q.down && st_q.count >= top |=>
            timer_count == $past(st_q.count) - TCS_STEP;
    endproperty
    a_updn_turn: assert property (p_updn_turn) else $error("up/down mode did not turn at top");

    property p_ceil_max;
        mode == TCS_WGM_NORMAL && timer_count == TCS_MAX |-> count_ceiling;
    endproperty
    a_ceil_max: assert property (p_ceil_max) else $error("ceiling flag missing at maximum");

    property p_div1024_quiet;
        cs == TCS_CS_DIV1024 && quiet && prescaler_count != 10'h3FF |=> $stable(timer_count);
    endproperty
    a_div1024_quiet: assert property (p_div1024_quiet) else $error("divide by 1024 counted off phase");

    property p_hi_read;
        bus_req.rd && bus_req.addr == TCS_ADDR_CNT_HI |=> rd_data == $past(st_q.hold);
    endproperty
    a_hi_read: assert property (p_hi_read) else $error("high byte read bypassed holding byte");

    property p_hi_write;
        bus_req.wr && bus_req.addr == TCS_ADDR_CNT_HI && cs == TCS_CS_STOP && !count_clear |=>
            st_q.hold == $past(bus_req.wdata) && $stable(timer_count);
    endproperty
    a_hi_write: assert property (p_hi_write) else $error("high byte write reached the counter");

    property p_ovf_clear;
        bus_req.wr && bus_req.addr == TCS_ADDR_FLAGS && bus_req.wdata[TCS_OVF_BIT] && !tick |=> !overflow_flag;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared by host");

    c_wrap: cover property (tick && st_q.count == TCS_MAX);
    c_ctc_wrap: cover property (tick && mode == TCS_WGM_CTC_A && st_q.count == top);
    c_updn_turn: cover property (mode == TCS_WGM_UPDN_A && st_q.down ##1 !st_q.down);
    c_ext_tick: cover property (cs == TCS_CS_EXT_RISE && tick);
    c_write_vs_tick: cover property (wr_cnt && tick);
endmodule : tcs_timer

// >>> verilog/tcs_pkg.sv
// Purpose: shared constants and types of the timer clock select and counter core
// Assumes: 8-bit host data bus, one system clock
// Notes: byte locations are index values on the 4-bit host address
package tcs_pkg;
    ////////////////////////////////////////////////////////////////////////
    // host byte locations
    localparam logic [3:0] TCS_ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] TCS_ADDR_CTRL_B = 4'h1;
    localparam logic [3:0] TCS_ADDR_CNT_LO = 4'h2;
    localparam logic [3:0] TCS_ADDR_CNT_HI = 4'h3;
    localparam logic [3:0] TCS_ADDR_CMPA_LO = 4'h4;
    localparam logic [3:0] TCS_ADDR_CMPA_HI = 4'h5;
    localparam logic [3:0] TCS_ADDR_CMPB_LO = 4'h6;
    localparam logic [3:0] TCS_ADDR_CMPB_HI = 4'h7;
    localparam logic [3:0] TCS_ADDR_FLAGS = 4'h8;
    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int TCS_CS_MSB = 2;
    localparam int TCS_CS_LSB = 0;
    localparam int TCS_WGMH_MSB = 4;
    localparam int TCS_WGMH_LSB = 3;
    localparam int TCS_WGML_MSB = 1;
    localparam int TCS_WGML_LSB = 0;
    localparam int TCS_OVF_BIT = 0;
    ////////////////////////////////////////////////////////////////////////
    // clock select codes
    localparam logic [2:0] TCS_CS_STOP = 3'h0;
    localparam logic [2:0] TCS_CS_SYS = 3'h1;
    localparam logic [2:0] TCS_CS_DIV8 = 3'h2;
    localparam logic [2:0] TCS_CS_DIV64 = 3'h3;
    localparam logic [2:0] TCS_CS_DIV256 = 3'h4;
    localparam logic [2:0] TCS_CS_DIV1024 = 3'h5;
    localparam logic [2:0] TCS_CS_EXT_FALL = 3'h6;
    localparam logic [2:0] TCS_CS_EXT_RISE = 3'h7;
    ////////////////////////////////////////////////////////////////////////
    // waveform modes with their own sequence; all others count as normal
    localparam logic [3:0] TCS_WGM_NORMAL = 4'h0;
    localparam logic [3:0] TCS_WGM_CTC_A = 4'h4;
    localparam logic [3:0] TCS_WGM_UPDN_A = 4'hB;
    ////////////////////////////////////////////////////////////////////////
    // prescaler and counter
    localparam int TCS_PRESC_W = 10;
    localparam logic [9:0] TCS_PRESC_RST = 10'h000;
    localparam logic [9:0] TCS_PRESC_STEP = 10'h001;
    localparam int TCS_TAP8_BITS = 3;
    localparam int TCS_TAP64_BITS = 6;
    localparam int TCS_TAP256_BITS = 8;
    localparam int TCS_TAP1024_BITS = 10;
    localparam logic [15:0] TCS_MAX = 16'hFFFF;
    localparam logic [15:0] TCS_FLOOR = 16'h0000;
    localparam logic [15:0] TCS_STEP = 16'h0001;
    localparam logic [15:0] TCS_COUNT_RST = 16'h0000;
    localparam logic [7:0] TCS_BYTE_RST = 8'h00;
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [3:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } tcs_bus_req_type;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [15:0] count;
        logic [7:0] hold;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic down;
        logic ovf;
        logic floor;
        logic ceil;
        logic tick;
        logic [7:0] rdata;
    } tcs_state_type;

    typedef struct packed {
        logic latch;
        logic sync;
        logic prev;
        logic rise;
        logic fall;
    } tcs_pin_state_type;
endpackage : tcs_pkg

// >>> verilog/tcs_prescaler.sv
// Purpose: free-running shared prescaler with four divide taps
// Assumes: one system clock
// Notes: a tap pulses one cycle when its low bits are all ones
`timescale 1ns/100ps
module tcs_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic presc_clear,
    // taps
    output logic [3:0] taps,
    output logic [tcs_pkg::TCS_PRESC_W-1:0] presc_count
);
    import tcs_pkg::*;
    logic [TCS_PRESC_W-1:0] cnt_q;
    logic [TCS_PRESC_W-1:0] cnt_d;

    ////////////////////////////////////////////////////////////////////////
    // runs whatever the clock select says clear restarts every tap
    always_comb begin
        cnt_d = presc_clear ? TCS_PRESC_RST : cnt_q + TCS_PRESC_STEP;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= TCS_PRESC_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // taps divide by 8, 64, 256 and 1024
    assign taps[0] = &cnt_q[TCS_TAP8_BITS-1:0];
    assign taps[1] = &cnt_q[TCS_TAP64_BITS-1:0];
    assign taps[2] = &cnt_q[TCS_TAP256_BITS-1:0];
    assign taps[3] = &cnt_q[TCS_TAP1024_BITS-1:0];
    assign presc_count = cnt_q;
endmodule : tcs_prescaler

// >>> verilog/tcs_pin_edge.sv
// Purpose: samples the external count pin and detects its edges
// Assumes: pin may be asynchronous to clk
// Notes: rise and fall are one-cycle pulses from flops
`timescale 1ns/100ps
module tcs_pin_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pin
    input wire logic external_count_pin,
    // edges
    output logic rise,
    output logic fall
);
    import tcs_pkg::*;
    tcs_pin_state_type st_q;
    tcs_pin_state_type st_d;
    logic latch_q;

    ////////////////////////////////////////////////////////////////////////
    // flop takes the pin at the falling edge and holds it until the next falling edge
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            latch_q <= 1'b0;
        end else begin
            latch_q <= external_count_pin;
        end
    end

    // latch, sync and edge flops give 2.5 to 3.5 cycles to the counter
    always_comb begin
        st_d = st_q;
        st_d.latch = 1'b0;
        st_d.sync = latch_q;
        st_d.prev = st_q.sync;
        st_d.rise = st_q.sync & ~st_q.prev;
        st_d.fall = ~st_q.sync & st_q.prev;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign rise = st_q.rise;
    assign fall = st_q.fall;
endmodule : tcs_pin_edge

// >>> tb/tcs_host_model.sv
// Purpose: host processor model driving the timer byte bus
// Assumes: a request is launched by non-blocking assignment at a rising clk edge
// Notes: every access is followed by one idle cycle; read data is taken at the next falling edge
`timescale 1ns/100ps
module tcs_host_model (
    // clock
    input wire logic clk,
    // byte bus
    output tcs_pkg::tcs_bus_req_type bus_req,
    input wire logic [7:0] rd_data
);
    import tcs_pkg::*;
    initial bus_req = '0;
    ////////////////////////////////////////////////////////////////////////
    // one byte access: request held through the taking edge, then released
    task automatic acc(input logic [3:0] a, input logic r, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        bus_req <= '{addr: a, rd: r, wr: ~r, wdata: d};
        @(posedge clk);
        bus_req <= '0;
        @(negedge clk);
        q = rd_data;
    endtask : acc
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(a, 1'h0, d, q);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        acc(a, 1'h1, 8'h00, q);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // 16-bit pairs: the low byte location triggers the transfer
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(4'(a + 4'h1), v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(4'(a + 4'h1), v[15:8]);
    endtask : rd16
endmodule : tcs_host_model

// >>> tb/tb.sv
// Purpose: self-checking bench of the timer clock select and counter core
// Assumes: host model drives the byte bus; bench drives pin and loose controls
// Notes: random values come from a fixed seed so every run repeats
`timescale 1ns/100ps
module tb;
    import tcs_pkg::*;
    logic clk, rst, external_count_pin, presc_clear, count_clear;
    tcs_bus_req_type bus_req;
    logic [7:0] rd_data, b;
    logic [15:0] timer_count, v, r;
    logic count_floor, count_ceiling, overflow_flag, timer_tick;
    logic [TCS_PRESC_W-1:0] prescaler_count, p;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int seed, k, w, n;

    tcs_timer i_tcs_timer (.clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .external_count_pin(external_count_pin), .presc_clear(presc_clear), .count_clear(count_clear),
        .timer_count(timer_count), .count_floor(count_floor), .count_ceiling(count_ceiling),
        .overflow_flag(overflow_flag), .timer_tick(timer_tick), .prescaler_count(prescaler_count));
    tcs_host_model i_tcs_host_model (.clk(clk), .bus_req(bus_req), .rd_data(rd_data));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // a hang would otherwise never reach the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    function automatic int tap_div(input int code);
        return 8 << (code == 2 ? 0 : code == 3 ? 3 : code == 4 ? 5 : 7);
    endfunction : tap_div
    task automatic wait_tick(input int lim, output int cnt);
        cnt = 0;
        do begin
            @(negedge clk);
            cnt++;
        end while (timer_tick !== 1'h1 && cnt < lim);
    endtask : wait_tick
    task automatic wait_val(input logic [15:0] val);
        for (int i = 0; i < 3000 && timer_count !== val; i++) begin
            @(negedge clk);
        end
    endtask : wait_val
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 17502;
        rst = 1'h1;
        external_count_pin = 1'h0;
        presc_clear = 1'h0;
        count_clear = 1'h0;
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        check("count_rst", timer_count, TCS_COUNT_RST);
        check("floor_rst", count_floor, 16'h0001);
        check("ovf_rst", overflow_flag, 16'h0000);
        for (k = 0; k < 6; k++) begin
            v = 16'($random(seed));
            i_tcs_host_model.wr16(TCS_ADDR_CNT_LO, v);
            check("count_wr", timer_count, v);
            i_tcs_host_model.rd16(TCS_ADDR_CNT_LO, r);
            check("count_rd", r, v);
        end
        repeat (20) @(negedge clk);
        check("stopped", timer_count, v);
        // one holding byte feeds two low-byte writes
        i_tcs_host_model.wr(TCS_ADDR_CNT_HI, 8'hA5);
        i_tcs_host_model.wr(TCS_ADDR_CNT_LO, 8'h11);
        i_tcs_host_model.wr(TCS_ADDR_CMPA_LO, 8'h22);
        check("hold_shared", timer_count, 16'hA511);
        i_tcs_host_model.wr(TCS_ADDR_CNT_HI, 8'h3C);
        check("hi_wr_hold", timer_count, 16'hA511);
        i_tcs_host_model.rd16(TCS_ADDR_CMPA_LO, r);
        check("cmp_direct", r, 16'hA522);
        i_tcs_host_model.rd(TCS_ADDR_CNT_HI, b);
        check("hi_rd_hold", b, 8'h3C);
        i_tcs_host_model.wr16(TCS_ADDR_CMPB_LO, 16'h5AC3);
        i_tcs_host_model.rd16(TCS_ADDR_CMPB_LO, r);
        check("cmpb_rw", r, 16'h5AC3);
        i_tcs_host_model.rd(4'hF, b);
        check("unmapped", b, 8'h00);
        p = prescaler_count;
        repeat (5) @(negedge clk);
        check("presc_free", prescaler_count, 10'(p + 10'h005));
        @(posedge clk);
        presc_clear <= 1'h1;
        repeat (2) @(negedge clk);
        check("presc_clr", prescaler_count, TCS_PRESC_RST);
        @(posedge clk);
        presc_clear <= 1'h0;
        i_tcs_host_model.wr(TCS_ADDR_CTRL_B, TCS_CS_SYS);
        v = timer_count;
        repeat (10) @(negedge clk);
        check("sys_rate", timer_count, 16'(v + 16'h000A));
        for (k = 2; k <= 5; k++) begin
            i_tcs_host_model.wr(TCS_ADDR_CTRL_B, TCS_CS_STOP);
            i_tcs_host_model.wr(TCS_ADDR_CTRL_B, 8'(k));
            wait_tick(tap_div(k) + 4, n);
            check("first_tick", 16'(n <= tap_div(k) + 2), 16'h0001);
            wait_tick(tap_div(k) + 4, n);
            check("tap_period", 16'(n), 16'(tap_div(k)));
        end
        // the pin is steady for several cycles whenever the select changes
        for (k = 7; k >= 6; k--) begin
            i_tcs_host_model.wr(TCS_ADDR_CTRL_B, 8'(k));
            for (w = 0; w < 6; w++) begin
                v = timer_count;
                @(posedge clk);
                external_count_pin <= ~external_count_pin;
                repeat (2) @(posedge clk);
                @(negedge clk);
                check("pin_early", timer_count, v);
                @(negedge clk);
                check("pin_count", timer_count, 16'(v + (external_count_pin == (k == 7))));
                repeat ($unsigned($random(seed)) % 3) @(posedge clk);
            end
        end
        i_tcs_host_model.wr(TCS_ADDR_CTRL_B, TCS_CS_STOP);
        i_tcs_host_model.wr16(TCS_ADDR_CNT_LO, 16'hFFFD);
        i_tcs_host_model.wr(TCS_ADDR_FLAGS, 8'h01);
        i_tcs_host_model.wr(TCS_ADDR_CTRL_B, TCS_CS_SYS);
        wait_val(TCS_MAX);
        check("ceil_max", count_ceiling, 16'h0001);
        @(negedge clk);
        check("wrap", timer_count, TCS_FLOOR);
        check("floor", count_floor, 16'h0001);
        check("ovf", overflow_flag, 16'h0001);
        // up/down mode between zero and compare A
        i_tcs_host_model.wr(TCS_ADDR_CTRL_B, TCS_CS_STOP);
        i_tcs_host_model.wr16(TCS_ADDR_CMPA_LO, 16'h0005);
        i_tcs_host_model.wr16(TCS_ADDR_CNT_LO, 16'h0000);
        i_tcs_host_model.wr(TCS_ADDR_CTRL_A, 8'h03);
        i_tcs_host_model.wr(TCS_ADDR_CTRL_B, 8'h11);
        wait_val(16'h0005);
        check("ceil_cmp", count_ceiling, 16'h0001);
        @(negedge clk);
        check("count_down", timer_count, 16'h0004);
        i_tcs_host_model.wr(TCS_ADDR_CTRL_A, 8'h00);
        i_tcs_host_model.wr(TCS_ADDR_CTRL_B, 8'h09);
        wait_val(16'h0005);
        @(negedge clk);
        check("cmp_clear", timer_count, 16'h0000);
        wait_val(16'h0003);
        @(posedge clk);
        count_clear <= 1'h1;
        @(posedge clk);
        count_clear <= 1'h0;
        @(negedge clk);
        check("clear", timer_count, 16'h0000);
        i_tcs_host_model.wr(TCS_ADDR_CNT_HI, 8'h00);
        fork
            i_tcs_host_model.wr(TCS_ADDR_CNT_LO, 8'h04);
            begin
                @(posedge clk);
                count_clear <= 1'h1;
                @(posedge clk);
                count_clear <= 1'h0;
            end
        join
        check("wr_first", timer_count, 16'h0004);
        give_verdict();
    end
endmodule : tb
